/* rtl/port_b_mux_regs.vh */
`ifndef PORT_B_MUX_REGS_VH
`define PORT_B_MUX_REGS_VH

// ----------------------------------------
// Pin positions within the port
// ----------------------------------------
`define PIN_MISO      0
`define PIN_MOSI      1
`define PIN_IRQ1      2
`define PIN_AMP0N     3
`define PIN_AMP0P     4
`define PIN_IRQ2      5
`define PIN_STAGE1B   6
`define PIN_SCLK      7

// ----------------------------------------
// Reset values of the registered outputs
// ----------------------------------------
`define OVR_RESET     8'h00
`define DI_RESET      1'b0

`endif

/* rtl/port_b_alternate_function_mux.v */
`timescale 1ns/10ps
`include "port_b_mux_regs.vh"

module port_b_alternate_function_mux #(
  parameter PINS = 8                          // Pins in the port
) (
  input  wire            sys_clk,             // I/O clock
  input  wire            reset,               // Async reset, high
  input  wire            ireset_ok,           // Internal reset qualifier, high when out of reset
  input  wire            serial_unit_enable,  // Serial unit enabled
  input  wire            serial_master_select,// Serial unit is master
  input  wire            serial_pin_select,   // Serial pins on this port when low
  input  wire            global_pullup_disable,// Global pull-up disable
  input  wire            dir_bit_7,           // Pin 7 direction bit
  input  wire            dir_bit_1,           // Pin 1 direction bit
  input  wire            dir_bit_0,           // Pin 0 direction bit
  input  wire            out_latch_7,         // Pin 7 output latch bit
  input  wire            out_latch_1,         // Pin 1 output latch bit
  input  wire            out_latch_0,         // Pin 0 output latch bit
  input  wire            serial_clk_out,      // Serial clock from master
  input  wire            serial_mosi_out,     // Master data out
  input  wire            serial_miso_out,     // Slave data out
  input  wire            stage_out_0b_enable, // Stage output 0B enabled
  input  wire            stage_out_0b_value,  // Stage output 0B level
  input  wire            stage_out_1b_enable, // Stage output 1B enabled
  input  wire            stage_out_1b_value,  // Stage output 1B level
  input  wire            stage_out_2a_enable, // Stage output 2A enabled
  input  wire            stage_out_2a,        // Stage output 2A level
  input  wire            stage_out_2b_enable, // Stage output 2B enabled
  input  wire            stage_out_2b,        // Stage output 2B level
  input  wire            ext_irq_1_enabled,   // External interrupt 1 enabled
  input  wire            ext_irq_2_enabled,   // External interrupt 2 enabled
  input  wire            chan4_digital_off,   // Channel 4 digital disable
  input  wire            chan5_digital_off,   // Channel 5 digital disable
  input  wire            chan6_digital_off,   // Channel 6 digital disable
  input  wire            chan7_digital_off,   // Channel 7 digital disable
  input  wire            amp0_digital_off,    // Amplifier 0 digital disable
  input  wire [PINS-1:0] pin_in_sync,         // Synchronised pin inputs
  output reg  [PINS-1:0] pullup_override_en,  // Pull-up override enables
  output reg  [PINS-1:0] pullup_override_val, // Pull-up override values
  output reg  [PINS-1:0] dir_override_en,     // Direction override enables
  output reg  [PINS-1:0] dir_override_val,    // Direction override values
  output reg  [PINS-1:0] value_override_en,   // Value override enables
  output reg  [PINS-1:0] value_override_val,  // Value override values
  output reg  [PINS-1:0] input_enable_override_en, // Input enable override enables
  output reg  [PINS-1:0] input_enable_override_val,// Input enable override values
  output reg  [PINS-1:0] pin_change_src,      // Pin-change sources
  output reg             serial_clk_in,       // Slave clock to serial unit
  output reg             serial_mosi_in,      // Data into slave
  output reg             serial_miso_in,      // Data into master
  output reg             ext_irq_1,           // External interrupt 1 input
  output reg             ext_irq_2            // External interrupt 2 input
);

  // ----------------------------------------
  // Behaviour notes
  // ----------------------------------------
  // Every override leaves one clock after its inputs change.
  // A pin forced to input keeps a pull-up chosen by its latch bit, off while pull-ups are globally disabled.
  // Stage outputs win over the serial unit on pins 7, 1 and 0,
  // so a running stage never fights a forced input.
  // The direction bits act in the plain port logic; with no
  // override the port keeps using them, so they pass unused here.
  // Pins 4 and 3 carry only their digital-off override.
  // Analog pins rely on software to pick input without pull-up.
  // Reset clears every override so the port registers rule.

  // ----------------------------------------
  // Serial mode terms
  // ----------------------------------------
  // Pin select is low when the serial function sits on these pins
  wire sel_here;                              // Serial function on this port
  wire as_master;                             // Active master on this port
  wire as_slave;                              // Active slave on this port
  wire pu_ok;                                 // Pull-ups not globally disabled
  wire in_ok;                                 // Serial inputs may pass

  // Active modes and qualifiers
  assign sel_here  = ~serial_pin_select;
  assign as_master = serial_unit_enable & serial_master_select & sel_here;
  assign as_slave  = serial_unit_enable & ~serial_master_select & sel_here;
  assign pu_ok     = ~global_pullup_disable;
  assign in_ok     = sel_here & ireset_ok;

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------
  // Gate a pin level on its way to the serial unit
  function gate_in;
    input pin_level;                          // Synchronised pin level
    input pass;                               // Serial inputs allowed
    begin
      gate_in = pin_level & pass;
    end
  endfunction

  // Pick the stage level while its output runs
  function stage_or_serial;
    input stage_en;                           // Stage output enabled
    input stage_level;                        // Stage output level
    input serial_level;                       // Serial unit output level
    begin
      stage_or_serial = stage_en ? stage_level : serial_level;
    end
  endfunction

  // Pull-up of a pin forced to input
  function forced_pullup;
    input latch_bit;                          // Output latch bit of the pin
    input allowed;                            // Pull-ups not globally disabled
    begin
      forced_pullup = latch_bit & allowed;
    end
  endfunction

  // ----------------------------------------
  // Next values of the registered outputs
  // ----------------------------------------
  reg [PINS-1:0] pullup_en_d;                 // Pull-up override enables
  reg [PINS-1:0] pullup_val_d;                // Pull-up override values
  reg [PINS-1:0] dir_en_d;                    // Direction override enables
  reg [PINS-1:0] dir_val_d;                   // Direction override values
  reg [PINS-1:0] value_en_d;                  // Value override enables
  reg [PINS-1:0] value_val_d;                 // Value override values
  reg [PINS-1:0] input_en_d;                  // Input enable override enables
  reg [PINS-1:0] input_val_d;                 // Input enable override values
  reg            serial_clk_d;                // Slave clock toward the serial unit
  reg            serial_mosi_d;               // Slave data toward the serial unit
  reg            serial_miso_d;               // Master data toward the serial unit
  reg            ext_irq_1_d;                 // Interrupt 1 level
  reg            ext_irq_2_d;                 // Interrupt 2 level

  // ----------------------------------------
  // Override generation
  // ----------------------------------------
  // Combine the alternate functions of every pin
  always @* begin
    // Idle pins leave the port registers in charge
    pullup_en_d  = `OVR_RESET;
    pullup_val_d = `OVR_RESET;
    dir_en_d     = `OVR_RESET;
    dir_val_d    = `OVR_RESET;
    value_en_d   = `OVR_RESET;
    value_val_d  = `OVR_RESET;
    input_en_d   = `OVR_RESET;
    input_val_d  = `OVR_RESET;

    // Pin 7: slave clock in, master clock out or stage 0B out
    // A running stage output wins over the serial forcing
    pullup_en_d[`PIN_SCLK]  = as_slave & ~stage_out_0b_enable;
    pullup_val_d[`PIN_SCLK] = forced_pullup(out_latch_7, pu_ok);
    dir_en_d[`PIN_SCLK]     = as_slave | stage_out_0b_enable;
    dir_val_d[`PIN_SCLK]    = stage_out_0b_enable;
    value_en_d[`PIN_SCLK]   = as_master | stage_out_0b_enable;
    value_val_d[`PIN_SCLK]  = stage_or_serial(stage_out_0b_enable, stage_out_0b_value, serial_clk_out);
    input_en_d[`PIN_SCLK]   = chan4_digital_off;
    input_val_d[`PIN_SCLK]  = 1'h0;

    // Pin 6: stage 1B output, channel 7 input
    // The direction bit is ignored while stage 1B runs
    pullup_en_d[`PIN_STAGE1B]  = 1'h0;
    pullup_val_d[`PIN_STAGE1B] = 1'h0;
    dir_en_d[`PIN_STAGE1B]     = stage_out_1b_enable;
    dir_val_d[`PIN_STAGE1B]    = 1'h1;
    value_en_d[`PIN_STAGE1B]   = stage_out_1b_enable;
    value_val_d[`PIN_STAGE1B]  = stage_out_1b_value;
    input_en_d[`PIN_STAGE1B]   = chan7_digital_off;
    input_val_d[`PIN_STAGE1B]  = 1'h0;

    // Pin 5: interrupt 2 and channel 6
    // An enabled interrupt keeps the input alive in sleep
    pullup_en_d[`PIN_IRQ2]  = 1'h0;
    pullup_val_d[`PIN_IRQ2] = 1'h0;
    dir_en_d[`PIN_IRQ2]     = 1'h0;
    dir_val_d[`PIN_IRQ2]    = 1'h0;
    value_en_d[`PIN_IRQ2]   = 1'h0;
    value_val_d[`PIN_IRQ2]  = 1'h0;
    input_en_d[`PIN_IRQ2]   = chan6_digital_off | ext_irq_2_enabled;
    input_val_d[`PIN_IRQ2]  = ext_irq_2_enabled;

    // Pin 4: amplifier 0 positive input
    // Only the digital input is switched off
    pullup_en_d[`PIN_AMP0P]  = 1'h0;
    pullup_val_d[`PIN_AMP0P] = 1'h0;
    dir_en_d[`PIN_AMP0P]     = 1'h0;
    dir_val_d[`PIN_AMP0P]    = 1'h0;
    value_en_d[`PIN_AMP0P]   = 1'h0;
    value_val_d[`PIN_AMP0P]  = 1'h0;
    input_en_d[`PIN_AMP0P]   = amp0_digital_off;
    input_val_d[`PIN_AMP0P]  = 1'h0;

    // Pin 3: amplifier 0 negative input
    // Shares the disable bit with pin 4
    pullup_en_d[`PIN_AMP0N]  = 1'h0;
    pullup_val_d[`PIN_AMP0N] = 1'h0;
    dir_en_d[`PIN_AMP0N]     = 1'h0;
    dir_val_d[`PIN_AMP0N]    = 1'h0;
    value_en_d[`PIN_AMP0N]   = 1'h0;
    value_val_d[`PIN_AMP0N]  = 1'h0;
    input_en_d[`PIN_AMP0N]   = amp0_digital_off;
    input_val_d[`PIN_AMP0N]  = 1'h0;

    // Pin 2: interrupt 1 and channel 5
    // An enabled interrupt keeps the input alive in sleep
    pullup_en_d[`PIN_IRQ1]  = 1'h0;
    pullup_val_d[`PIN_IRQ1] = 1'h0;
    dir_en_d[`PIN_IRQ1]     = 1'h0;
    dir_val_d[`PIN_IRQ1]    = 1'h0;
    value_en_d[`PIN_IRQ1]   = 1'h0;
    value_val_d[`PIN_IRQ1]  = 1'h0;
    input_en_d[`PIN_IRQ1]   = chan5_digital_off | ext_irq_1_enabled;
    input_val_d[`PIN_IRQ1]  = ext_irq_1_enabled;

    // Pin 1: data out of master, into slave, or stage 2B
    // Slave mode forces input; stage 2B wins when running
    pullup_en_d[`PIN_MOSI]  = as_slave & ~stage_out_2b_enable;
    pullup_val_d[`PIN_MOSI] = forced_pullup(out_latch_1, pu_ok);
    dir_en_d[`PIN_MOSI]     = as_slave | stage_out_2b_enable;
    dir_val_d[`PIN_MOSI]    = stage_out_2b_enable;
    value_en_d[`PIN_MOSI]   = as_master | stage_out_2b_enable;
    value_val_d[`PIN_MOSI]  = stage_or_serial(stage_out_2b_enable, stage_out_2b, serial_mosi_out);
    input_en_d[`PIN_MOSI]   = 1'h0;
    input_val_d[`PIN_MOSI]  = 1'h0;

    // Pin 0: data into master, out of slave, or stage 2A
    // Master mode forces input; stage 2A wins when running
    pullup_en_d[`PIN_MISO]  = as_master & ~stage_out_2a_enable;
    pullup_val_d[`PIN_MISO] = forced_pullup(out_latch_0, pu_ok);
    dir_en_d[`PIN_MISO]     = as_master | stage_out_2a_enable;
    dir_val_d[`PIN_MISO]    = stage_out_2a_enable;
    value_en_d[`PIN_MISO]   = as_slave | stage_out_2a_enable;
    value_val_d[`PIN_MISO]  = stage_or_serial(stage_out_2a_enable, stage_out_2a, serial_miso_out);
    input_en_d[`PIN_MISO]   = 1'h0;
    input_val_d[`PIN_MISO]  = 1'h0;
  end

  // ----------------------------------------
  // Input routing
  // ----------------------------------------
  // Pin levels handed to the serial unit and the interrupts
  always @* begin
    // Serial inputs only while the port carries the serial pins
    serial_clk_d  = gate_in(pin_in_sync[`PIN_SCLK], in_ok);
    serial_mosi_d = gate_in(pin_in_sync[`PIN_MOSI], in_ok);
    serial_miso_d = gate_in(pin_in_sync[`PIN_MISO], in_ok);
    // Interrupt pins pass straight through
    ext_irq_1_d   = pin_in_sync[`PIN_IRQ1];
    ext_irq_2_d   = pin_in_sync[`PIN_IRQ2];
  end

  // ----------------------------------------
  // Registered override outputs
  // ----------------------------------------
  // Pull-up and direction overrides
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      // Nothing overridden while in reset
      pullup_override_en  <= `OVR_RESET;
      pullup_override_val <= `OVR_RESET;
      dir_override_en     <= `OVR_RESET;
      dir_override_val    <= `OVR_RESET;
    end else begin
      // Follow the combined alternate functions
      pullup_override_en  <= pullup_en_d;
      pullup_override_val <= pullup_val_d;
      dir_override_en     <= dir_en_d;
      dir_override_val    <= dir_val_d;
    end
  end

  // Value and input enable overrides
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      // Nothing overridden while in reset
      value_override_en         <= `OVR_RESET;
      value_override_val        <= `OVR_RESET;
      input_enable_override_en  <= `OVR_RESET;
      input_enable_override_val <= `OVR_RESET;
    end else begin
      // Follow the combined alternate functions
      value_override_en         <= value_en_d;
      value_override_val        <= value_val_d;
      input_enable_override_en  <= input_en_d;
      input_enable_override_val <= input_val_d;
    end
  end

  // ----------------------------------------
  // Registered pin routing
  // ----------------------------------------
  // Serial and interrupt inputs
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      // Quiet inputs while in reset
      serial_clk_in  <= `DI_RESET;
      serial_mosi_in <= `DI_RESET;
      serial_miso_in <= `DI_RESET;
      ext_irq_1      <= `DI_RESET;
      ext_irq_2      <= `DI_RESET;
    end else begin
      // Routed pin levels
      serial_clk_in  <= serial_clk_d;
      serial_mosi_in <= serial_mosi_d;
      serial_miso_in <= serial_miso_d;
      ext_irq_1      <= ext_irq_1_d;
      ext_irq_2      <= ext_irq_2_d;
    end
  end

  // Pin-change sources follow every pin
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      // No pin-change activity in reset
      pin_change_src <= `OVR_RESET;
    end else begin
      // Each pin feeds its own source
      pin_change_src <= pin_in_sync;
    end
  end

endmodule

/* sim/port_b_mux_props_properties.sv */
`timescale 1ns/10ps
// ----------------------------------------
// Override and routing checks
// ----------------------------------------
module port_b_mux_props #(parameter PINS = 8) (
  input wire sys_clk, reset, ireset_ok, serial_unit_enable, // Clock, reset, serial enable
  input wire serial_master_select, serial_pin_select, global_pullup_disable, out_latch_7, // Controls
  input wire stage_out_0b_enable, stage_out_0b_value, stage_out_1b_enable, stage_out_1b_value, // Stage
  input wire stage_out_2a_enable, stage_out_2b_enable, ext_irq_2_enabled, chan4_digital_off, // Enables
  input wire [PINS-1:0] pin_in_sync, pullup_override_en, pullup_override_val, dir_override_en, // Vectors
  input wire [PINS-1:0] dir_override_val, value_override_en, value_override_val, pin_change_src, // Vectors
  input wire [PINS-1:0] input_enable_override_en, input_enable_override_val // Input enables
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  // Serial function placed on this port
  sequence slave_s; serial_unit_enable && !serial_pin_select && !serial_master_select; endsequence
  sequence master_s; serial_unit_enable && !serial_pin_select && serial_master_select; endsequence
  clk_pin_input_a: assert property (slave_s ##0 !stage_out_0b_enable |=>
    dir_override_en[7] && !dir_override_val[7]) else $error("clock pin not forced to input");
  clk_pin_pullup_a: assert property (slave_s ##0 !stage_out_0b_enable |=> pullup_override_en[7] &&
    pullup_override_val[7] == ($past(out_latch_7) && !$past(global_pullup_disable))) else $error("bad pull-up");
  data_in_slave_a: assert property (slave_s ##0 !stage_out_2b_enable |=>
    dir_override_en[1] && !dir_override_val[1]) else $error("data-in pin not forced to input");
  data_in_master_a: assert property (master_s ##0 !stage_out_2a_enable |=>
    dir_override_en[0] && !dir_override_val[0]) else $error("data-return pin not forced to input");
  clk_master_dir_a: assert property (master_s ##0 !stage_out_0b_enable |=>
    !dir_override_en[7]) else $error("clock pin direction overridden in master mode");
  stage_1b_drive_a: assert property (stage_out_1b_enable |=> dir_override_en[6] && dir_override_val[6] &&
    value_override_en[6] && value_override_val[6] == $past(stage_out_1b_value)) else $error("pin 6 not driven");
  stage_0b_drive_a: assert property (stage_out_0b_enable |=> dir_override_en[7] &&
    dir_override_val[7] && value_override_en[7] && value_override_val[7] == $past(stage_out_0b_value))
    else $error("pin 7 not driven");
  irq2_input_on_a: assert property (ext_irq_2_enabled |=>
    input_enable_override_en[5] && input_enable_override_val[5]) else $error("pin 5 input not enabled");
  chan4_input_off_a: assert property (chan4_digital_off |=>
    input_enable_override_en[7] && !input_enable_override_val[7]) else $error("pin 7 input not disabled");
  pin_change_a: assert property (1'b1 |=> pin_change_src == $past(pin_in_sync))
    else $error("pin-change sources wrong");
endmodule
bind port_b_alternate_function_mux port_b_mux_props #(.PINS(PINS)) props (.*);

/* sim/periph_model.sv */
`timescale 1ns/10ps
module periph_model (
  input  wire        sys_clk,            // I/O clock
  input  wire [19:0] cmd,                // Requested peripheral levels
  output reg  [19:0] sig = 20'h0_0000    // Levels the peripherals present
);
  // Peripherals change on the clock; enables and levels are plain bits
  always @(posedge sys_clk) begin
    sig <= cmd;
  end
endmodule

/* sim/port_b_alternate_function_mux_tb_top.sv */
`timescale 1ns/10ps
module port_b_alternate_function_mux_tb_top;
  logic        sys_clk = 1'b0;        // I/O clock
  logic        reset   = 1'b1;        // Async reset
  logic [19:0] cmd     = 20'h0_0000;  // Peripheral request
  logic [8:0]  rg      = 9'h000;      // Port bits and selects
  logic [7:0]  pins    = 8'h00;       // Pin levels
  int          err_count = 0;         // Mismatches
  int          checks_done = 0;       // Comparisons
  wire  [19:0] ps;                    // Peripheral levels
  wire  [7:0]  pu_en, pu_v, dd_en, dd_v, pv_en, pv_v, ie_en, ie_v, pc; // Overrides
  wire         s_clk, s_mosi, s_miso, irq1, irq2; // Routed inputs
  initial forever #20 sys_clk = ~sys_clk;
  periph_model pm (.sys_clk(sys_clk), .cmd(cmd), .sig(ps));
  port_b_alternate_function_mux #(.PINS(8)) dut (
    .sys_clk(sys_clk), .reset(reset), .ireset_ok(rg[0]), .serial_pin_select(rg[1]),
    .global_pullup_disable(rg[2]), .dir_bit_7(rg[3]), .dir_bit_1(rg[4]), .dir_bit_0(rg[5]),
    .out_latch_7(rg[6]), .out_latch_1(rg[7]), .out_latch_0(rg[8]), .pin_in_sync(pins),
    .serial_unit_enable(ps[0]), .serial_master_select(ps[1]), .serial_clk_out(ps[2]),
    .serial_mosi_out(ps[3]), .serial_miso_out(ps[4]), .stage_out_0b_enable(ps[5]),
    .stage_out_0b_value(ps[6]), .stage_out_1b_enable(ps[7]), .stage_out_1b_value(ps[8]),
    .stage_out_2a_enable(ps[9]), .stage_out_2a(ps[10]), .stage_out_2b_enable(ps[11]),
    .stage_out_2b(ps[12]), .ext_irq_1_enabled(ps[13]), .ext_irq_2_enabled(ps[14]),
    .chan4_digital_off(ps[15]), .chan5_digital_off(ps[16]), .chan6_digital_off(ps[17]),
    .chan7_digital_off(ps[18]), .amp0_digital_off(ps[19]), .pullup_override_en(pu_en),
    .pullup_override_val(pu_v), .dir_override_en(dd_en), .dir_override_val(dd_v),
    .value_override_en(pv_en), .value_override_val(pv_v), .input_enable_override_en(ie_en),
    .input_enable_override_val(ie_v), .pin_change_src(pc), .serial_clk_in(s_clk),
    .serial_mosi_in(s_mosi), .serial_miso_in(s_miso), .ext_irq_1(irq1), .ext_irq_2(irq2));
  // Apply one setting, let partner and mux registers settle
  task automatic apply(input logic [19:0] c, input logic [8:0] r, input logic [7:0] p);
    @(posedge sys_clk);
    cmd <= c;
    rg <= r;
    pins <= p;
    repeat (3) @(posedge sys_clk);
    #1;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge sys_clk);
    reset <= 1'b0;
    apply(20'h0_0001, 9'h1F9, 8'h83);            // Slave mode, pull-ups allowed
    chk(dd_en & 8'h83, 8'h82);
    chk(dd_v & 8'h82, 8'h00);
    chk(pu_en & 8'h82, 8'h82);
    chk(pu_v & 8'h82, 8'h82);
    chk({5'h00, s_clk, s_mosi, s_miso}, 8'h07);
    apply(20'h0_0001, 9'h1FD, 8'h83);            // Global pull-up disable set
    chk(pu_v & 8'h82, 8'h00);
    $display("test slave done");
    apply(20'h0_000F, 9'h1F9, 8'h00);            // Master mode, clock and data high
    chk(dd_en & 8'h83, 8'h01);
    chk(dd_v & 8'h01, 8'h00);
    chk(pu_en & pu_v & 8'h01, 8'h01);
    chk(pv_en & pv_v & 8'h82, 8'h82);
    apply(20'h0_000F, 9'h1FB, 8'h83);            // Serial pins moved off this port
    chk(dd_en & 8'h83, 8'h00);
    chk({5'h00, s_clk, s_mosi, s_miso}, 8'h00);
    apply(20'h0_0001, 9'h1F8, 8'h83);            // Internal reset qualifier low
    chk({5'h00, s_clk, s_mosi, s_miso}, 8'h00);
    $display("test master done");
    apply(20'h0_00E0, 9'h1FB, 8'h00);            // Stage outputs 0B high, 1B low
    chk(dd_en & dd_v & 8'hC0, 8'hC0);
    chk(pv_en & 8'hC0, 8'hC0);
    chk(pv_v & 8'hC0, 8'h80);
    apply(20'h0_00E1, 9'h1F9, 8'h00);            // Stage 0B over slave forcing
    chk(dd_v & 8'h80, 8'h80);
    apply(20'h0_0E00, 9'h1FB, 8'h00);            // Stage 2A high, 2B low
    chk(dd_en & dd_v & 8'h03, 8'h03);
    chk(pv_v & 8'h03, 8'h01);
    chk(pv_en & 8'h03, 8'h03);
    $display("test stage done");
    apply(20'hF_8000, 9'h1FD, 8'h24);
    chk(ie_en & 8'hFC, 8'hFC);
    chk(ie_v & 8'hFC, 8'h00);
    apply(20'hF_E000, 9'h1F9, 8'h24);            // Interrupts enabled
    chk(ie_v & 8'h24, 8'h24);
    chk({6'h00, irq2, irq1}, 8'h03);
    apply(20'h0_0000, 9'h000, 8'h5A);            // Nothing active
    chk(pu_en | dd_en | pv_en | ie_en, 8'h00);
    chk(pc, 8'h5A);
    chk({6'h00, irq2, irq1}, 8'h00);
    $display("test analog done");
    finish_test;
  end
  // Watchdog against a hang
  initial begin
    repeat (1000) @(posedge sys_clk);
    err_count++;
    $display("[ERR] %0t watchdog expired", $time);
    finish_test;
  end
endmodule
